/* ric_irq_ctrl.v */
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// Behaviour
// RL1 - Two flag and two enable registers
// RL2 - Bit 7 selects set or clear
// RL3 - Host may raise or clear flags; bit 7 of the low register (start of frame) is not host-writable
// RL4 - Any enabled event sets status indication bit
// RL5 - Interrupt pin driven when pin enabled
// RL6 - Timer underflow sets its own flag
// RL7 - Transmit end sets transmit-done flag
// RL8 - Receive end sets receive-done flag
// RL9 - Command back to idle sets flag
// RL10 - One level sets both FIFO thresholds
// RL11 - High alert rise sets flag
// RL12 - Low alert rise sets flag
// RL13 - Any error bit sets error flag
// RL14 - Card detect sets card flag
// RL15 - Start of frame sets flag
// RL16 - Global flag: any enabled flag set
// RL17 - Ones set or clear; zeros keep
// RL18 - Flags sticky; pin drops when none
// RL19 - FIFO fill range is 512 bytes
`include "ric_regs.vh"
module ric_irq_ctrl #(
  parameter NUM_TIMERS = 4,
  parameter FIFO_DEPTH = 512,
  parameter FILL_W = 10
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Event sources
  input wire [NUM_TIMERS-1:0] timer_underflow,
  input wire tx_eof_start,
  input wire rx_end,
  input wire cmd_to_idle,
  input wire [7:0] error_bits,
  input wire card_detected,
  input wire rx_sof,
  input wire [FILL_W-1:0] fifo_fill,
  // Interrupt outputs
  output reg irq_pin,
  output wire irq_status
);

  // Register state
  reg [7:0] flags_lo_r; // Low flag register
  reg [7:0] flags_hi_r; // High flag register, bit 7 global
  reg [7:0] en_lo_r; // Low enable register
  reg [7:0] en_hi_r; // High enable register
  reg pin_en_r; // Pin signalling activation
  reg [8:0] level_r; // FIFO warning level
  reg hi_alert_d_r; // Previous high alert level
  reg lo_alert_d_r; // Previous low alert level
  reg err_d_r; // Previous any-error level

  // Bus decode
  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire sel_set = pwdata[`RIC_SEL_BIT];
  wire [6:0] wr_bits = pwdata[6:0];
  wire mapped = (paddr == `RIC_ADDR_FLAGS_LO) | (paddr == `RIC_ADDR_FLAGS_HI) |
                (paddr == `RIC_ADDR_EN_LO) | (paddr == `RIC_ADDR_EN_HI) |
                (paddr == `RIC_ADDR_STATUS1) | (paddr == `RIC_ADDR_CTRL) |
                (paddr == `RIC_ADDR_LEVEL) | (paddr == `RIC_ADDR_FILL);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // FIFO alerts from one level value [RL10] [RL19]
  wire [FILL_W-1:0] level_ext = {{(FILL_W-9){1'b0}}, level_r};
  wire [FILL_W-1:0] depth_w = FIFO_DEPTH[FILL_W-1:0];
  wire hi_alert = (depth_w - fifo_fill) <= level_ext; // [RL10]
  wire lo_alert = fifo_fill <= level_ext; // [RL10]
  wire any_err = |error_bits; // [RL13]

  // Hardware event vectors, one bit per flag position
  reg [7:0] ev_lo;
  reg [7:0] ev_hi;
  always @* begin
    ev_lo = 8'h00;
    ev_lo[`RIC_LO_TX] = tx_eof_start; // [RL7]
    ev_lo[`RIC_LO_RX] = rx_end; // [RL8]
    ev_lo[`RIC_LO_IDLE] = cmd_to_idle; // [RL9]
    ev_lo[`RIC_LO_HI_ALERT] = hi_alert & ~hi_alert_d_r; // [RL11]
    ev_lo[`RIC_LO_LO_ALERT] = lo_alert & ~lo_alert_d_r; // [RL12]
    ev_lo[`RIC_LO_ERR] = any_err & ~err_d_r; // [RL13]
    ev_lo[`RIC_LO_CARD] = card_detected; // [RL14]
    ev_lo[`RIC_LO_SOF] = rx_sof; // [RL15]
    ev_hi = 8'h00;
    ev_hi[NUM_TIMERS-1:0] = timer_underflow; // [RL6]
  end

  // Software write masks: ones set or clear per selector [RL2] [RL17]
  wire wr_flo = wr_acc & (paddr == `RIC_ADDR_FLAGS_LO);
  wire wr_fhi = wr_acc & (paddr == `RIC_ADDR_FLAGS_HI);
  wire wr_elo = wr_acc & (paddr == `RIC_ADDR_EN_LO);
  wire wr_ehi = wr_acc & (paddr == `RIC_ADDR_EN_HI);
  wire [7:0] sw_set = {1'b0, sel_set ? wr_bits : 7'h00}; // [RL3]
  wire [7:0] sw_clr = {1'b0, sel_set ? 7'h00 : wr_bits}; // [RL3]

  // Global flag: any enabled source flag [RL16]
  wire [7:0] src_hi = {1'b0, flags_hi_r[6:0]};
  wire global_nxt = |(flags_lo_r & en_lo_r) | |(src_hi & en_hi_r);
  wire [7:0] pend_nxt = flags_lo_r & en_lo_r;

  // Flag and enable registers; hardware set beats software clear [RL1] [RL18]
  always @(posedge ref_clk) begin
    if (reset) begin
      flags_lo_r <= `RIC_RST_BYTE;
      flags_hi_r <= `RIC_RST_BYTE;
      en_lo_r <= `RIC_RST_BYTE;
      en_hi_r <= `RIC_RST_BYTE;
      pin_en_r <= 1'b0;
      level_r <= `RIC_RST_LEVEL;
      // Track live levels so a level already high at reset is no false edge
      hi_alert_d_r <= hi_alert;
      lo_alert_d_r <= lo_alert;
      err_d_r <= any_err;
      irq_pin <= 1'b0;
    end else if (clk_en) begin
      hi_alert_d_r <= hi_alert;
      lo_alert_d_r <= lo_alert;
      err_d_r <= any_err;
      // Low flags; bit 7 of the low register is a source, set by hardware only
      flags_lo_r <= (flags_lo_r & ~(wr_flo ? sw_clr : 8'h00)) |
                    (wr_flo ? sw_set : 8'h00) | ev_lo; // [RL17] [RL18]
      // High flags 0..6; global bit follows sources
      flags_hi_r[6:0] <= (flags_hi_r[6:0] & ~(wr_fhi ? sw_clr[6:0] : 7'h00)) |
                         (wr_fhi ? sw_set[6:0] : 7'h00) | ev_hi[6:0]; // [RL6] [RL17]
      flags_hi_r[`RIC_HI_GLOBAL] <= global_nxt; // [RL16]
      if (wr_elo) begin
        en_lo_r <= sel_set ? (en_lo_r | {1'b0, wr_bits}) : (en_lo_r & ~{1'b0, wr_bits}); // [RL2]
      end
      if (wr_ehi) begin
        en_hi_r <= sel_set ? (en_hi_r | {1'b0, wr_bits}) : (en_hi_r & ~{1'b0, wr_bits}); // [RL2]
      end
      if (wr_acc & (paddr == `RIC_ADDR_CTRL)) begin
        pin_en_r <= pwdata[`RIC_CTRL_PIN_EN];
      end
      if (wr_acc & (paddr == `RIC_ADDR_LEVEL)) begin
        level_r <= pwdata[8:0];
      end
      // Pin drops once no enabled flag remains [RL5] [RL18]
      irq_pin <= pin_en_r & global_nxt;
    end
  end

  // Status indication independent of pin activation [RL4]
  assign irq_status = flags_hi_r[`RIC_HI_GLOBAL];
  wire unused_pend = |pend_nxt;

  // Read mux
  always @* begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      case (paddr)
        `RIC_ADDR_FLAGS_LO: prdata[7:0] = flags_lo_r;
        `RIC_ADDR_FLAGS_HI: prdata[7:0] = flags_hi_r;
        `RIC_ADDR_EN_LO: prdata[7:0] = en_lo_r;
        `RIC_ADDR_EN_HI: prdata[7:0] = en_hi_r;
        `RIC_ADDR_STATUS1: prdata[2:0] = {lo_alert, hi_alert, irq_status}; // [RL4]
        `RIC_ADDR_CTRL: prdata[0] = pin_en_r;
        `RIC_ADDR_LEVEL: prdata[8:0] = level_r;
        `RIC_ADDR_FILL: prdata[FILL_W-1:0] = fifo_fill;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule // ric_irq_ctrl

/* ric_regs.vh */
`ifndef RIC_REGS_VH
`define RIC_REGS_VH
// Register byte addresses on the APB bus
`define RIC_ADDR_FLAGS_LO 12'h000
`define RIC_ADDR_FLAGS_HI 12'h004
`define RIC_ADDR_EN_LO 12'h008
`define RIC_ADDR_EN_HI 12'h00c
`define RIC_ADDR_STATUS1 12'h010
`define RIC_ADDR_CTRL 12'h014
`define RIC_ADDR_LEVEL 12'h018
`define RIC_ADDR_FILL 12'h01c
// Set/clear selector bit in every flag and enable register
`define RIC_SEL_BIT 7
// Low flag register bit positions
`define RIC_LO_TX 0
`define RIC_LO_RX 1
`define RIC_LO_IDLE 2
`define RIC_LO_HI_ALERT 3
`define RIC_LO_LO_ALERT 4
`define RIC_LO_ERR 5
`define RIC_LO_CARD 6
`define RIC_LO_SOF 7
// High flag register bit positions
`define RIC_HI_TIMER0 0
`define RIC_HI_GLOBAL 7
// Status and control bit positions
`define RIC_ST_IRQ 0
`define RIC_ST_HI_ALERT 1
`define RIC_ST_LO_ALERT 2
`define RIC_CTRL_PIN_EN 0
// Reset values
`define RIC_RST_BYTE 8'h00
`define RIC_RST_LEVEL 9'h008
`endif

/* ric_props.sv */
`timescale 1ns/10ps
module ric_props(
  // Watched bus and outputs
  input wire ref_clk, reset, clk_en, psel, penable, pwrite, pready, pslverr, irq_pin, irq_status,
  input wire [11:0] paddr, input wire [31:0] prdata);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Access phase, and a cycle with no register write
  sequence s_acc; psel && penable; endsequence
  sequence s_nowr; !(psel && penable && pwrite); endsequence
  property p_rdy; s_acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("rdy");
  property p_err; s_acc ##0 paddr > 12'h01c |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("err");
  property p_ok; s_acc ##0 (paddr < 12'h020) && (paddr[1:0] == 2'b00) |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("ok");
  property p_zro; s_acc ##0 (pslverr && !pwrite) |-> prdata == 32'h0; endproperty
  a_zro: assert property (p_zro) else $error("zro");
  property p_pin; irq_pin |-> irq_status; endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_frz; !clk_en |=> $stable(irq_status); endproperty
  a_frz: assert property (p_frz) else $error("frz");
  // Global flag holds unless software writes
  property p_stk; s_nowr ##1 s_nowr ##0 irq_status |=> ##1 irq_status; endproperty
  a_stk: assert property (p_stk) else $error("stk");
  property p_rst; disable iff (1'b0) reset && clk_en |=> !irq_pin && !irq_status; endproperty
  a_rst: assert property (p_rst) else $error("rst");
endmodule // ric_props
bind ric_irq_ctrl ric_props u_props(.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .irq_pin(irq_pin), .irq_status(irq_status), .paddr(paddr), .prdata(prdata));

/* ric_src.sv */
`timescale 1ns/10ps
module ric_src(
  // Clock and kick mask
  input wire ref_clk, input wire [8:0] go,
  // Event pulses
  output reg [8:0] ev);
  // Kicked sources fire one cycle
  always @(posedge ref_clk) begin
    ev <= go;
  end
endmodule // ric_src

/* tb_top.sv */
`timescale 1ns/10ps
`include "ric_regs.vh"
module tb_top;
  reg ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h0; reg [31:0] pwdata = 32'h0, q; reg [8:0] go = 9'h0;
  reg [7:0] error_bits = 8'h0; reg [9:0] fifo_fill = 10'h064;
  wire [8:0] ev; wire [31:0] prdata; wire pready, pslverr, irq_pin, irq_status;
  integer fails = 0, total_checks = 0, cyc = 0;
  always #2 ref_clk = ~ref_clk;
  ric_src src(.ref_clk(ref_clk), .go(go), .ev(ev));
  ric_irq_ctrl dut(.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .timer_underflow(ev[3:0]), .tx_eof_start(ev[4]),
    .rx_end(ev[5]), .cmd_to_idle(ev[6]), .card_detected(ev[7]), .rx_sof(ev[8]),
    .error_bits(error_bits), .fifo_fill(fifo_fill), .irq_pin(irq_pin), .irq_status(irq_status));
  task test_done;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin fails = fails + 1; test_done; end
  end
  task chk(input [31:0] s, input [31:0] e);
    total_checks = total_checks + 1;
    if (s !== e) begin fails = fails + 1; $display("BAD %0t %h %h", $time, s, e); end
  endtask
  // One APB transfer, then an idle cycle
  task apb(input [11:0] a, input w, input [31:0] d);
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge ref_clk) penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata; psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task wr(input [11:0] a, input [31:0] d); apb(a, 1'b1, d); endtask
  task rd(input [11:0] a, input [31:0] e); apb(a, 1'b0, 32'h0); chk(q, e); endtask
  task kick(input [8:0] k); go <= k; @(posedge ref_clk) go <= 9'h0; repeat (3) @(posedge ref_clk);
  endtask
  task t_regs;
    rd(`RIC_ADDR_EN_LO, 32'h0);
    rd(`RIC_ADDR_LEVEL, 32'h8);
    wr(`RIC_ADDR_EN_LO, 32'hff);
    rd(`RIC_ADDR_EN_LO, 32'h7f);
    wr(`RIC_ADDR_EN_LO, 32'h5d);
    rd(`RIC_ADDR_EN_LO, 32'h22);
    rd(12'h020, 32'h0);
    $display("regs done");
  endtask
  task t_evt;
    wr(`RIC_ADDR_CTRL, 32'h1);
    kick(9'h020);
    rd(`RIC_ADDR_FLAGS_LO, 32'h2);
    rd(`RIC_ADDR_STATUS1, 32'h1);
    chk({31'h0, irq_pin}, 32'h1);
    wr(`RIC_ADDR_FLAGS_LO, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq_pin}, 32'h0);
    $display("event done");
  endtask
  task t_src;
    wr(`RIC_ADDR_CTRL, 32'h0);
    wr(`RIC_ADDR_EN_HI, 32'h81);
    wr(`RIC_ADDR_FLAGS_HI, 32'h81);
    clk_en <= 1'b0; repeat (2) @(posedge ref_clk); clk_en <= 1'b1; @(posedge ref_clk);
    chk({30'h0, irq_pin, irq_status}, 32'h1);
    wr(`RIC_ADDR_FLAGS_HI, 32'h1);
    kick(9'h002);
    rd(`RIC_ADDR_FLAGS_HI, 32'h2);
    fifo_fill <= 10'h004; error_bits <= 8'h10; kick(9'h1f0);
    fifo_fill <= 10'h1fc; repeat (3) @(posedge ref_clk);
    rd(`RIC_ADDR_FLAGS_LO, 32'hff);
    $display("sources done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_regs; t_evt; t_src;
    test_done;
  end
endmodule // tb_top
